/* boot_strap_port_merge_config.sv */
// Purpose: Samples boot straps at fundamental reset and applies them
// Assumes: NRST is power-on reset; strap and reset pins are asynchronous
// Notes:   Override and control registers reached over a plain port
`timescale 1ns/100ps
`default_nettype none
module boot_strap_port_merge_config (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        FUNDAMENTAL_RESET_PIN_N,
  input  wire logic        COMMON_CLOCK_DOWNSTREAM,
  input  wire logic        COMMON_CLOCK_UPSTREAM,
  input  wire logic        MASTER_SMBUS_SLOW_STRAP,
  input  wire logic        MERGE_PAIR_ZERO_ONE,
  input  wire logic        MERGE_PAIR_TWO_THREE,
  input  wire logic        MERGE_PAIR_FOUR_FIVE,
  input  wire logic        HALT_AFTER_RESET,
  input  wire logic [3:0]  SWITCH_MODE_STRAP,
  input  wire logic        REFCLK_FREQ_SELECT,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic [23:0] PORT_PIN_IN,
  output logic      [23:0] PORT_CORE_IN,
  input  wire logic [23:0] PORT_CORE_OUT,
  output logic      [23:0] PORT_PIN_OUT,
  input  wire logic        CFG_REQ,
  input  wire logic [4:0]  CFG_DEV,
  output logic             CFG_UR,
  output logic             CFG_ACK,
  input  wire logic        SMB_REQ,
  input  wire logic [2:0]  SMB_PORT,
  output logic             SMB_ALLOW,
  output logic             SMB_BLOCK,
  output logic             CORE_RESET_N,
  output logic             SWITCH_HALTED,
  output logic             REFCLK_IS_125,
  output logic      [4:0]  PLL_REF_MULT,
  output logic      [3:0]  CORE_CLK_DIV,
  output logic             MSMB_SLOW,
  output logic      [9:0]  MSMB_CLK_DIV,
  output logic             MODE_NORMAL,
  output logic             MODE_EEPROM_INIT,
  output logic             MODE_RESERVED,
  output logic             UPSTREAM_COMMON_CLK,
  output logic             DOWNSTREAM_COMMON_CLK,
  output logic      [5:0]  PORT_DOWNSTREAM,
  output logic      [5:0]  PORT_ENABLED,
  output logic      [71:0] LANE_PORT,
  output logic      [35:0] MAX_LINK_WIDTH
);

  // Pin synchronisers
  logic        rst_pin_m_q;
  logic        rst_pin_s_q;
  logic [10:0] strap_m_q;
  logic [10:0] strap_s_q;
  logic [23:0] port_in_m_q;
  logic [23:0] port_in_s_q;
  logic        refsel_m_q;
  logic        refsel_s_q;
  logic [10:0] strap_pins;

  assign strap_pins = {SWITCH_MODE_STRAP, HALT_AFTER_RESET, MERGE_PAIR_FOUR_FIVE,
                       MERGE_PAIR_TWO_THREE, MERGE_PAIR_ZERO_ONE, MASTER_SMBUS_SLOW_STRAP,
                       COMMON_CLOCK_UPSTREAM, COMMON_CLOCK_DOWNSTREAM};

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_pin_m_q <= 1'b0;
      rst_pin_s_q <= 1'b0;
      strap_m_q   <= strap_cfg_pkg::STRAP_RST;
      strap_s_q   <= strap_cfg_pkg::STRAP_RST;
      port_in_m_q <= 24'h0;
      port_in_s_q <= 24'h0;
      refsel_m_q  <= 1'b0;
      refsel_s_q  <= 1'b0;
    end else begin
      rst_pin_m_q <= FUNDAMENTAL_RESET_PIN_N;
      rst_pin_s_q <= rst_pin_m_q;
      strap_m_q   <= strap_pins;
      strap_s_q   <= strap_m_q;
      port_in_m_q <= PORT_PIN_IN;
      port_in_s_q <= port_in_m_q;
      refsel_m_q  <= REFCLK_FREQ_SELECT;
      refsel_s_q  <= refsel_m_q;
    end
  end

  // Reset sequencer
  strap_cfg_pkg::seq_t   seq_q;
  strap_cfg_pkg::seq_t   seq_d;
  strap_cfg_pkg::strap_t eff_cfg;
  logic [4:0]            init_cnt_q;
  logic                  init_done;
  logic                  halt_q;
  logic                  warm_req;
  logic                  halt_clr;
  logic                  wr_ctl;

  assign wr_ctl    = REG_WR && REG_ADDR == strap_cfg_pkg::OFS_CONTROL;
  assign warm_req  = wr_ctl && REG_WDATA[strap_cfg_pkg::CTL_WARM_BIT];
  assign halt_clr  = wr_ctl && !REG_WDATA[strap_cfg_pkg::CTL_HALT_BIT];
  assign init_done = init_cnt_q == 5'(strap_cfg_pkg::INIT_CYC - 1);

  always_comb begin
    seq_d = seq_q;
    unique case (seq_q)
      strap_cfg_pkg::SEQ_RESET:  if (rst_pin_s_q) seq_d = strap_cfg_pkg::SEQ_SAMPLE;
      strap_cfg_pkg::SEQ_SAMPLE: seq_d = strap_cfg_pkg::SEQ_INIT;
      strap_cfg_pkg::SEQ_INIT: begin
        if (init_done) begin
          seq_d = eff_cfg.halt ? strap_cfg_pkg::SEQ_HALT : strap_cfg_pkg::SEQ_RUN;
        end
      end
      strap_cfg_pkg::SEQ_HALT:   if (!halt_q) seq_d = strap_cfg_pkg::SEQ_RUN;
      strap_cfg_pkg::SEQ_RUN:    if (warm_req) seq_d = strap_cfg_pkg::SEQ_INIT;
      default:                   seq_d = strap_cfg_pkg::SEQ_RESET;
    endcase
    if (!rst_pin_s_q) seq_d = strap_cfg_pkg::SEQ_RESET;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      seq_q <= strap_cfg_pkg::SEQ_RESET;
    end else begin
      seq_q <= seq_d;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      init_cnt_q <= 5'h00;
    end else if (seq_q != strap_cfg_pkg::SEQ_INIT) begin
      init_cnt_q <= 5'h00;
    end else if (!init_done) begin
      init_cnt_q <= init_cnt_q + 5'h01;
    end
  end

  // Sampled and cold-reset strap copies
  strap_cfg_pkg::strap_t sampled_q;
  strap_cfg_pkg::strap_t cold_q;
  logic                  cold_pending_q;
  logic                  sample_now;

  assign sample_now = seq_q == strap_cfg_pkg::SEQ_SAMPLE;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sampled_q <= strap_cfg_pkg::STRAP_RST;
    end else if (sample_now) begin
      sampled_q <= strap_s_q;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cold_q         <= strap_cfg_pkg::STRAP_RST;
      cold_pending_q <= 1'b1;
    end else if (sample_now && cold_pending_q) begin
      cold_q         <= strap_s_q;
      cold_pending_q <= 1'b0;
    end
  end

  // Overrides during the reset sequence
  logic [10:0]           ovr_q;
  logic                  ovr_valid_q;
  logic                  in_reset_seq;

  assign in_reset_seq = seq_q != strap_cfg_pkg::SEQ_RUN;
  assign eff_cfg = ovr_valid_q ? ((ovr_q & strap_cfg_pkg::OVR_MASK) |
                                  (sampled_q & ~strap_cfg_pkg::OVR_MASK)) : sampled_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ovr_q       <= strap_cfg_pkg::STRAP_RST;
      ovr_valid_q <= 1'b0;
    end else if (sample_now) begin
      ovr_valid_q <= 1'b0;
    end else if (REG_WR && REG_ADDR == strap_cfg_pkg::OFS_OVERRIDE && in_reset_seq) begin
      ovr_q       <= REG_WDATA[10:0];
      ovr_valid_q <= 1'b1;
    end
  end

  // Configuration in force, frozen when the sequence leaves init
  strap_cfg_pkg::strap_t run_cfg_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_cfg_q <= strap_cfg_pkg::STRAP_RST;
    end else if (seq_q == strap_cfg_pkg::SEQ_INIT && init_done) begin
      run_cfg_q <= eff_cfg;
    end
  end

  // Halt bit: setting wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      halt_q <= 1'b0;
    end else if (seq_q == strap_cfg_pkg::SEQ_INIT && init_done && eff_cfg.halt) begin
      halt_q <= 1'b1;
    end else if (halt_clr) begin
      halt_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CORE_RESET_N  <= 1'b0;
      SWITCH_HALTED <= 1'b0;
    end else begin
      CORE_RESET_N  <= seq_d == strap_cfg_pkg::SEQ_RUN;
      SWITCH_HALTED <= seq_d == strap_cfg_pkg::SEQ_HALT;
    end
  end

  // Clock and mode decode
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REFCLK_IS_125 <= 1'b0;
      PLL_REF_MULT  <= strap_cfg_pkg::PLL_MULT_LO;
      CORE_CLK_DIV  <= strap_cfg_pkg::CORE_DIV;
    end else begin
      REFCLK_IS_125 <= refsel_s_q;
      PLL_REF_MULT  <= refsel_s_q ? strap_cfg_pkg::PLL_MULT_HI : strap_cfg_pkg::PLL_MULT_LO;
      CORE_CLK_DIV  <= strap_cfg_pkg::CORE_DIV;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MSMB_SLOW    <= 1'b0;
      MSMB_CLK_DIV <= strap_cfg_pkg::SMB_DIV_FAST;
    end else begin
      MSMB_SLOW    <= run_cfg_q.slow;
      MSMB_CLK_DIV <= run_cfg_q.slow ? strap_cfg_pkg::SMB_DIV_SLOW
                                     : strap_cfg_pkg::SMB_DIV_FAST;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MODE_NORMAL      <= 1'b0;
      MODE_EEPROM_INIT <= 1'b0;
      MODE_RESERVED    <= 1'b0;
    end else begin
      MODE_NORMAL      <= run_cfg_q.mode == strap_cfg_pkg::MODE_NORMAL_CODE;
      MODE_EEPROM_INIT <= run_cfg_q.mode == strap_cfg_pkg::MODE_EEPROM_CODE;
      MODE_RESERVED    <= run_cfg_q.mode > strap_cfg_pkg::MODE_EEPROM_CODE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      UPSTREAM_COMMON_CLK   <= 1'b0;
      DOWNSTREAM_COMMON_CLK <= 1'b0;
      PORT_DOWNSTREAM       <= 6'h00;
      PORT_ENABLED          <= 6'h00;
    end else begin
      UPSTREAM_COMMON_CLK   <= run_cfg_q.common_clock_upstream;
      DOWNSTREAM_COMMON_CLK <= run_cfg_q.common_clock_downstream;
      PORT_DOWNSTREAM       <= 6'h3e;
      PORT_ENABLED          <= ~{run_cfg_q.merge[2], 1'b0, run_cfg_q.merge[1], 1'b0,
                                 run_cfg_q.merge[0], 1'b0};
    end
  end

  // Merge layout and port gating
  merge_cfg_if merge_if ();

  port_merge_map u_map (
    .clk       (CLK),
    .nrst      (NRST),
    .merge     (run_cfg_q.merge),
    .cfg       (merge_if.src),
    .lane_port (LANE_PORT),
    .max_width (MAX_LINK_WIDTH)
  );

  port_access_gate u_gate (
    .clk       (CLK),
    .nrst      (NRST),
    .cfg       (merge_if.dst),
    .pin_in    (port_in_s_q),
    .core_out  (PORT_CORE_OUT),
    .cfg_req   (CFG_REQ),
    .cfg_dev   (CFG_DEV),
    .smb_req   (SMB_REQ),
    .smb_port  (SMB_PORT),
    .core_in   (PORT_CORE_IN),
    .pin_out   (PORT_PIN_OUT),
    .cfg_ur    (CFG_UR),
    .cfg_ack   (CFG_ACK),
    .smb_allow (SMB_ALLOW),
    .smb_block (SMB_BLOCK)
  );

  // Register read port
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h0;
    unique case (REG_ADDR)
      strap_cfg_pkg::OFS_STATUS: begin
        rdata_d[10:0] = cold_q;
        rdata_d[strap_cfg_pkg::STS_HALTED_BIT] = seq_q == strap_cfg_pkg::SEQ_HALT;
        rdata_d[strap_cfg_pkg::STS_RUN_BIT]    = seq_q == strap_cfg_pkg::SEQ_RUN;
        rdata_d[strap_cfg_pkg::STS_RSVD_BIT]   = MODE_RESERVED;
        rdata_d[strap_cfg_pkg::STS_COLD_BIT]   = ~cold_pending_q;
      end
      strap_cfg_pkg::OFS_CONTROL:   rdata_d[strap_cfg_pkg::CTL_HALT_BIT] = halt_q;
      strap_cfg_pkg::OFS_OVERRIDE:  rdata_d[10:0] = ovr_q & strap_cfg_pkg::OVR_MASK;
      strap_cfg_pkg::OFS_EFFECTIVE: rdata_d[10:0] = eff_cfg;
      default:                      rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 32'h0;
    end else begin
      REG_RDATA <= REG_RD ? rdata_d : 32'h0;
    end
  end

endmodule
`default_nettype wire

/* boot_strap_port_merge_config_asserts.sv */
// Purpose: Port checks of the boot strap loader
// Assumes: One clock, NRST asynchronous active low
// Notes:   Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module strap_cfg_checker (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        FUNDAMENTAL_RESET_PIN_N,
  input wire logic        CFG_REQ,
  input wire logic [4:0]  CFG_DEV,
  input wire logic        CFG_UR,
  input wire logic        CFG_ACK,
  input wire logic        SMB_REQ,
  input wire logic [2:0]  SMB_PORT,
  input wire logic        SMB_BLOCK,
  input wire logic        CORE_RESET_N,
  input wire logic        SWITCH_HALTED,
  input wire logic [3:0]  CORE_CLK_DIV,
  input wire logic        MSMB_SLOW,
  input wire logic [9:0]  MSMB_CLK_DIV,
  input wire logic [5:0]  PORT_DOWNSTREAM,
  input wire logic [5:0]  PORT_ENABLED,
  input wire logic [23:0] PORT_PIN_OUT,
  input wire logic [23:0] PORT_CORE_IN,
  input wire logic [71:0] LANE_PORT,
  input wire logic [35:0] MAX_LINK_WIDTH
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_port_roles: assert property ($past(NRST) |-> PORT_DOWNSTREAM == 6'h3e)
    else $error("Port roles wrong");
  a_missing_dev_ur: assert property (CFG_REQ && CFG_DEV > 5'h05 |=> CFG_UR && !CFG_ACK)
    else $error("Missing device not refused");
  a_absorbed_cfg_ur: assert property (CFG_REQ && CFG_DEV < 5'h06 && CORE_RESET_N
    && !PORT_ENABLED[CFG_DEV[2:0]] |=> CFG_UR) else $error("Absorbed device accepted");
  a_absorbed_smb: assert property (SMB_REQ && SMB_PORT < 3'h6 && CORE_RESET_N
    && !PORT_ENABLED[SMB_PORT] |=> SMB_BLOCK) else $error("Absorbed port reachable");
  a_absorbed_quiet: assert property (CORE_RESET_N && $past(CORE_RESET_N, 3)
    && !PORT_ENABLED[1] |-> PORT_PIN_OUT[7:4] == 4'h0 && PORT_CORE_IN[7:4] == 4'h0)
    else $error("Absorbed port not silent");
  a_merged_lanes: assert property (CORE_RESET_N && $past(CORE_RESET_N, 3)
    && !PORT_ENABLED[1] |-> MAX_LINK_WIDTH[11:0] == 12'h008 && LANE_PORT[23:12] == 12'h000)
    else $error("Merged pair layout wrong");
  a_halt_holds: assert property (SWITCH_HALTED |-> !CORE_RESET_N)
    else $error("Halted switch left reset");
  a_pin_resets: assert property (!FUNDAMENTAL_RESET_PIN_N [*5] |-> !CORE_RESET_N
    && !SWITCH_HALTED) else $error("Reset pin not obeyed");
  a_smb_rate: assert property (MSMB_CLK_DIV == (MSMB_SLOW ? 10'h1f4 : 10'h07d))
    else $error("Master bus rate wrong");
  a_core_ratio: assert property (CORE_CLK_DIV == 4'ha)
    else $error("Core clock ratio wrong");
endmodule
bind boot_strap_port_merge_config strap_cfg_checker chk (.CLK(CLK), .NRST(NRST),
  .FUNDAMENTAL_RESET_PIN_N(FUNDAMENTAL_RESET_PIN_N), .CFG_REQ(CFG_REQ), .CFG_DEV(CFG_DEV),
  .CFG_UR(CFG_UR), .CFG_ACK(CFG_ACK), .SMB_REQ(SMB_REQ), .SMB_PORT(SMB_PORT),
  .SMB_BLOCK(SMB_BLOCK), .CORE_RESET_N(CORE_RESET_N), .SWITCH_HALTED(SWITCH_HALTED),
  .CORE_CLK_DIV(CORE_CLK_DIV), .MSMB_SLOW(MSMB_SLOW), .MSMB_CLK_DIV(MSMB_CLK_DIV),
  .PORT_DOWNSTREAM(PORT_DOWNSTREAM), .PORT_ENABLED(PORT_ENABLED), .PORT_PIN_OUT(PORT_PIN_OUT),
  .PORT_CORE_IN(PORT_CORE_IN), .LANE_PORT(LANE_PORT), .MAX_LINK_WIDTH(MAX_LINK_WIDTH));
`default_nettype wire

/* boot_strap_port_merge_config_bench.sv */
// Purpose: Self-checking bench for the boot strap loader
// Assumes: 50 MHz clock, straps from the board model
// Notes:   Ten cold resets with random straps, then a warm reset and a pin reset
`timescale 1ns/100ps
`default_nettype none
module boot_strap_port_merge_config_bench;
  logic CLK, NRST, go, FUNDAMENTAL_RESET_PIN_N, REFCLK_FREQ_SELECT, REG_WR, REG_RD;
  logic CFG_REQ, CFG_UR, CFG_ACK, SMB_REQ, SMB_ALLOW, SMB_BLOCK, CORE_RESET_N, SWITCH_HALTED;
  logic REFCLK_IS_125, MSMB_SLOW, MODE_NORMAL, MODE_EEPROM_INIT, MODE_RESERVED;
  logic UPSTREAM_COMMON_CLK, DOWNSTREAM_COMMON_CLK;
  logic [10:0] want, straps, v;
  logic [3:0]  REG_ADDR, CORE_CLK_DIV;
  logic [31:0] REG_WDATA, REG_RDATA, d;
  logic [23:0] PORT_PIN_IN, PORT_CORE_IN, PORT_CORE_OUT, PORT_PIN_OUT;
  logic [4:0]  CFG_DEV, PLL_REF_MULT;
  logic [2:0]  SMB_PORT;
  logic [9:0]  MSMB_CLK_DIV;
  logic [5:0]  PORT_DOWNSTREAM, PORT_ENABLED, e;
  logic [71:0] LANE_PORT;
  logic [35:0] MAX_LINK_WIDTH;
  int          num_errors, checked, cycles;
  strap_board_model board (.CLK, .NRST, .go, .want, .pin_n(FUNDAMENTAL_RESET_PIN_N), .straps);
  boot_strap_port_merge_config dut (.CLK, .NRST, .FUNDAMENTAL_RESET_PIN_N,
    .COMMON_CLOCK_DOWNSTREAM(straps[0]), .COMMON_CLOCK_UPSTREAM(straps[1]),
    .MASTER_SMBUS_SLOW_STRAP(straps[2]), .MERGE_PAIR_ZERO_ONE(straps[3]),
    .MERGE_PAIR_TWO_THREE(straps[4]), .MERGE_PAIR_FOUR_FIVE(straps[5]),
    .HALT_AFTER_RESET(straps[6]), .SWITCH_MODE_STRAP(straps[10:7]), .REFCLK_FREQ_SELECT,
    .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PORT_PIN_IN, .PORT_CORE_IN,
    .PORT_CORE_OUT, .PORT_PIN_OUT, .CFG_REQ, .CFG_DEV, .CFG_UR, .CFG_ACK, .SMB_REQ, .SMB_PORT,
    .SMB_ALLOW, .SMB_BLOCK, .CORE_RESET_N, .SWITCH_HALTED, .REFCLK_IS_125, .PLL_REF_MULT,
    .CORE_CLK_DIV, .MSMB_SLOW, .MSMB_CLK_DIV, .MODE_NORMAL, .MODE_EEPROM_INIT, .MODE_RESERVED,
    .UPSTREAM_COMMON_CLK, .DOWNSTREAM_COMMON_CLK, .PORT_DOWNSTREAM, .PORT_ENABLED, .LANE_PORT,
    .MAX_LINK_WIDTH);
  function automatic logic [5:0] en(input logic [2:0] m);
    return {~m[2], 1'b1, ~m[1], 1'b1, ~m[0], 1'b1};
  endfunction
  function automatic logic [35:0] wid(input logic [2:0] m);
    for (int k = 0; k < 3; k++) wid[12*k +: 12] = m[k] ? 12'h008 : 12'h104;
  endfunction
  function automatic logic [71:0] lanes(input logic [2:0] m);
    for (int l = 0; l < 24; l++) lanes[3*l +: 3] = 3'(l / 4) - 3'(m[l / 8] && (l % 8 > 3));
  endfunction
  function automatic logic [23:0] msk(input logic [5:0] en_v);
    for (int p = 0; p < 6; p++) msk[4*p +: 4] = {4{en_v[p]}};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checked++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= wd;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] rdv);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 rdv = REG_RDATA;
  endtask
  task automatic wait_up();
    int n;
    n = 0;
    while (CORE_RESET_N !== 1'b1 && SWITCH_HALTED !== 1'b1 && n < 80) begin
      @(posedge CLK);
      n++;
    end
    chk(n < 80, 1'b1);
    repeat (4) @(posedge CLK);
  endtask
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    {NRST, go, REG_WR, REG_RD, CFG_REQ, SMB_REQ, REFCLK_FREQ_SELECT} = '0;
    {want, REG_ADDR, REG_WDATA, PORT_PIN_IN, PORT_CORE_OUT, CFG_DEV, SMB_PORT} = '0;
    void'($urandom(32'he99c22dd));
    repeat (8) @(posedge CLK);
    for (int i = 0; i < 10; i++) begin
      v = 11'($urandom);
      if (i < 8) v[5:3] = i[2:0];
      if (i < 2) v[10:7] = i[3:0];
      e = en(v[5:3]);
      NRST <= 1'b0;
      REFCLK_FREQ_SELECT <= 1'($urandom);
      repeat (2) @(posedge CLK);
      NRST <= 1'b1;
      want <= v;
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      wait_up();
      rd(strap_cfg_pkg::OFS_STATUS, d);
      chk(d, {12'h001, v[10:7] > 4'h1, ~v[6], v[6], 5'h00, v});
      rd(strap_cfg_pkg::OFS_EFFECTIVE, d);
      chk(d, 32'(v));
      rd(4'h2, d);
      chk(d, 32'h0);
      chk(SWITCH_HALTED, v[6]);
      if (v[6]) begin
        wr(strap_cfg_pkg::OFS_OVERRIDE, 32'(~v));
        rd(strap_cfg_pkg::OFS_EFFECTIVE, d);
        chk(d, 32'((~v & strap_cfg_pkg::OVR_MASK) | (v & ~strap_cfg_pkg::OVR_MASK)));
        wr(strap_cfg_pkg::OFS_CONTROL, 32'h0);
        wait_up();
        chk(CORE_RESET_N, 1'b1);
      end
      chk({MODE_NORMAL, MODE_EEPROM_INIT, MODE_RESERVED},
          {v[10:7] == 4'h0, v[10:7] == 4'h1, v[10:7] > 4'h1});
      chk({MSMB_SLOW, UPSTREAM_COMMON_CLK, DOWNSTREAM_COMMON_CLK}, v[2:0]);
      chk({REFCLK_IS_125, PLL_REF_MULT},
          {REFCLK_FREQ_SELECT, REFCLK_FREQ_SELECT ? 5'h14 : 5'h19});
      chk(PORT_ENABLED, e);
      chk(MAX_LINK_WIDTH, wid(v[5:3]));
      chk(LANE_PORT, lanes(v[5:3]));
      PORT_PIN_IN <= 24'($urandom);
      PORT_CORE_OUT <= 24'($urandom);
      repeat (5) @(posedge CLK);
      #1 chk(PORT_CORE_IN, PORT_PIN_IN & msk(e));
      chk(PORT_PIN_OUT, PORT_CORE_OUT & msk(e));
      for (int k = 0; k < 8; k++) begin
        @(posedge CLK);
        CFG_REQ <= 1'b1;
        CFG_DEV <= 5'(k);
        SMB_REQ <= k < 6;
        SMB_PORT <= 3'(k);
        @(posedge CLK);
        CFG_REQ <= 1'b0;
        SMB_REQ <= 1'b0;
        #1 chk({CFG_UR, CFG_ACK}, (k > 5 || !e[k % 6]) ? 2'b10 : 2'b01);
        chk({SMB_BLOCK, SMB_ALLOW}, k > 5 ? 2'b00 : (e[k] ? 2'b01 : 2'b10));
      end
      $display("test %0d done", i);
    end
    if (v[6]) v = (~v & strap_cfg_pkg::OVR_MASK) | (v & ~strap_cfg_pkg::OVR_MASK);
    e = en(v[5:3]);
    wr(strap_cfg_pkg::OFS_CONTROL, 32'h2);
    repeat (4) @(posedge CLK);
    wait_up();
    rd(strap_cfg_pkg::OFS_EFFECTIVE, d);
    chk(d, 32'(v));
    chk(PORT_ENABLED, e);
    $display("test warm done");
    v = ~v;
    @(posedge CLK);
    want <= v;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    repeat (4) @(posedge CLK);
    chk(CORE_RESET_N, 1'b0);
    wait_up();
    rd(strap_cfg_pkg::OFS_EFFECTIVE, d);
    chk(d, 32'(v));
    $display("test pin done");
    stop_test();
  end
endmodule
`default_nettype wire

/* merge_cfg_if.sv */
// Purpose: Carries the merge layout between map and gate
// Assumes: One clock domain
// Notes:   absorbed marks odd ports swallowed by a merge
`timescale 1ns/100ps
`default_nettype none
interface merge_cfg_if;
  logic [5:0] absorbed;
  modport src (output absorbed);
  modport dst (input absorbed);
endinterface
`default_nettype wire

/* port_access_gate.sv */
// Purpose: Silences absorbed ports and answers access to them
// Assumes: Requests come from logic on the same clock
// Notes:   Answers one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module port_access_gate (
  input  wire logic        clk,
  input  wire logic        nrst,
  merge_cfg_if.dst         cfg,
  input  wire logic [23:0] pin_in,
  input  wire logic [23:0] core_out,
  input  wire logic        cfg_req,
  input  wire logic [4:0]  cfg_dev,
  input  wire logic        smb_req,
  input  wire logic [2:0]  smb_port,
  output logic      [23:0] core_in,
  output logic      [23:0] pin_out,
  output logic             cfg_ur,
  output logic             cfg_ack,
  output logic             smb_allow,
  output logic             smb_block
);
  function automatic logic [23:0] lane_mask(input logic [5:0] absorbed);
    for (int l = 0; l < 24; l++) lane_mask[l] = ~absorbed[l/4];
  endfunction

  function automatic logic gone(input logic [5:0] absorbed, input logic [4:0] dev);
    gone = (dev > 5'h05) || absorbed[dev[2:0]];
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_in <= 24'h0;
      pin_out <= 24'h0;
    end else begin
      core_in <= pin_in & lane_mask(cfg.absorbed);
      pin_out <= core_out & lane_mask(cfg.absorbed);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ur    <= 1'b0;
      cfg_ack   <= 1'b0;
      smb_allow <= 1'b0;
      smb_block <= 1'b0;
    end else begin
      cfg_ur    <= cfg_req & gone(cfg.absorbed, cfg_dev);
      cfg_ack   <= cfg_req & ~gone(cfg.absorbed, cfg_dev);
      smb_block <= smb_req & gone(cfg.absorbed, {2'b00, smb_port});
      smb_allow <= smb_req & ~gone(cfg.absorbed, {2'b00, smb_port});
    end
  end
endmodule
`default_nettype wire

/* port_merge_map.sv */
// Purpose: Turns the merge bits into lane ownership and link widths
// Assumes: Merge bits are static while the switch runs
// Notes:   All outputs registered
`timescale 1ns/100ps
`default_nettype none
module port_merge_map (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [2:0]  merge,
  merge_cfg_if.src         cfg,
  output logic      [71:0] lane_port,
  output logic      [35:0] max_width
);
  logic [5:0] absorbed_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      absorbed_q <= 6'h00;
    end else begin
      for (int p = 0; p < 3; p++) begin
        absorbed_q[2*p]   <= 1'b0;
        absorbed_q[2*p+1] <= merge[p];
      end
    end
  end
  assign cfg.absorbed = absorbed_q;

  // Odd port lanes become lanes 4..7 of the even port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_port <= 72'h0;
    end else begin
      for (int l = 0; l < 24; l++) begin
        if (merge[l/8]) lane_port[3*l +: 3] <= 3'((l/8)*2);
        else lane_port[3*l +: 3] <= 3'(l/4);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      max_width <= 36'h0;
    end else begin
      for (int p = 0; p < 6; p++) begin
        if (p % 2 == 1 && merge[p/2]) max_width[6*p +: 6] <= 6'h00;
        else if (merge[p/2]) max_width[6*p +: 6] <= strap_cfg_pkg::WIDTH_X8;
        else max_width[6*p +: 6] <= strap_cfg_pkg::WIDTH_X4;
      end
    end
  end
endmodule
`default_nettype wire

/* strap_board_model.sv */
// Purpose: Board side of the straps and the fundamental reset pin
// Assumes: One common reference clock feeds the board
// Notes:   Straps invert once their hold time has run out
`timescale 1ns/100ps
`default_nettype none
module strap_board_model (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        go,
  input  wire logic [10:0] want,
  output logic             pin_n,
  output logic      [10:0] straps
);
  // One source for both reference inputs, spread spectrum off
  localparam logic SSC_OFF = 1'b1;
  logic [4:0] cnt_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q  <= 5'h00;
      pin_n  <= 1'b0;
      straps <= 11'h000;
    end else if (go) begin
      cnt_q  <= 5'h01;
      pin_n  <= 1'b0;
      straps <= want;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == 5'h06) pin_n <= 1'b1;
      if (cnt_q == 5'h0e) begin
        cnt_q  <= 5'h00;
        straps <= ~want;
      end
    end
  end
endmodule
`default_nettype wire

/* strap_cfg_pkg.sv */
// Purpose: Shared constants and types for the boot strap loader
// Assumes: 50 MHz register clock
// Notes:   Offsets are byte addresses on the plain register port
package strap_cfg_pkg;

  localparam int unsigned NUM_PORTS      = 6;
  localparam int unsigned LANES_PER_PORT = 4;
  localparam int unsigned NUM_LANES      = NUM_PORTS * LANES_PER_PORT;
  localparam int unsigned NUM_PAIRS      = 3;

  // Register map
  localparam logic [3:0] OFS_STATUS    = 4'h0;
  localparam logic [3:0] OFS_CONTROL   = 4'h4;
  localparam logic [3:0] OFS_OVERRIDE  = 4'h8;
  localparam logic [3:0] OFS_EFFECTIVE = 4'hc;

  // Field positions
  localparam int unsigned CTL_HALT_BIT   = 0;
  localparam int unsigned CTL_WARM_BIT   = 1;
  localparam int unsigned STS_HALTED_BIT = 16;
  localparam int unsigned STS_RUN_BIT    = 17;
  localparam int unsigned STS_RSVD_BIT   = 18;
  localparam int unsigned STS_COLD_BIT   = 19;

  // Boot configuration vector
  typedef struct packed {
    logic [3:0] mode;
    logic       halt;
    logic [2:0] merge;
    logic       slow;
    logic       common_clock_upstream;
    logic       common_clock_downstream;
  } strap_t;

  localparam logic [10:0] STRAP_RST = 11'h000;
  localparam logic [10:0] OVR_MASK  = 11'h7fb;

  // Switch modes
  localparam logic [3:0] MODE_NORMAL_CODE = 4'h0;
  localparam logic [3:0] MODE_EEPROM_CODE = 4'h1;

  // Clocking
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned SERDES_MHZ   = 2500;
  localparam int unsigned CORE_MHZ     = 250;
  localparam int unsigned REF_LO_MHZ   = 100;
  localparam int unsigned REF_HI_MHZ   = 125;
  localparam int unsigned SMB_SLOW_HZ  = 100_000;
  localparam int unsigned SMB_FAST_HZ  = 400_000;
  localparam logic [4:0]  PLL_MULT_LO  = 5'(SERDES_MHZ / REF_LO_MHZ);
  localparam logic [4:0]  PLL_MULT_HI  = 5'(SERDES_MHZ / REF_HI_MHZ);
  localparam logic [3:0]  CORE_DIV     = 4'(SERDES_MHZ / CORE_MHZ);
  localparam logic [9:0]  SMB_DIV_SLOW = 10'(CLK_HZ / SMB_SLOW_HZ);
  localparam logic [9:0]  SMB_DIV_FAST = 10'(CLK_HZ / SMB_FAST_HZ);

  // PLL and SerDes settle time before the sequence continues
  localparam int unsigned INIT_NS  = 320;
  localparam int unsigned INIT_CYC = (INIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Link widths
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X8 = 6'h08;

  typedef enum logic [4:0] {
    SEQ_RESET  = 5'b00001,
    SEQ_SAMPLE = 5'b00010,
    SEQ_INIT   = 5'b00100,
    SEQ_HALT   = 5'b01000,
    SEQ_RUN    = 5'b10000
  } seq_t;

endpackage
